// ### rtl/gpa_pkg.sv
// Purpose: constants for the port A register block
// Assumes: AXI4-Lite, 32-bit data, 16-bit registers in the low half-word
// Notes: register index is the printed offset, byte address is four times it
package gpa_pkg;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_DIR = 10'h2C0;
  localparam logic [9:0] IDX_LVL = 10'h2C2;
  localparam logic [9:0] IDX_LAT = 10'h2C4;
  localparam logic [9:0] IDX_ODC = 10'h2C6;
  localparam logic [15:0] IMPL_MASK = 16'h079F;
  localparam logic [15:0] BIG_PKG_MASK = 16'h0780;
  localparam int BIT_OSC_ONLY = 3;
  localparam int BIT_CLK_PIN = 2;
  localparam logic [15:0] DIR_RESET = 16'h079F;
  localparam logic [15:0] LVL_RESET = 16'h0000;
  localparam logic [15:0] LAT_RESET = 16'h0000;
  localparam logic [15:0] ODC_RESET = 16'h0000;
  localparam logic [1:0] OSC_DISABLED = 2'h0;
  localparam logic [1:0] OSC_EXT_CLOCK = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpa_pkg

// ### rtl/gpa_pin_if.sv
// Purpose: carries pad levels into the synchroniser and back out
// Assumes: one clock domain on the synced side
// Notes: raw is asynchronous to the clock
`timescale 1ns/1ns
interface gpa_pin_if;
  logic [15:0] raw;
  logic [15:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface : gpa_pin_if

// ### rtl/gpa_sync.sv
// Purpose: two-flop synchroniser for the port pad inputs
// Assumes: asynchronous active-low reset
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module gpa_sync
  import gpa_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, low
  gpa_pin_if.sync pins // raw in, synced out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  always_comb begin
    s1_nxt = pins.raw;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_r <= LVL_RESET;
      s2_r <= LVL_RESET;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign pins.synced = s2_r;
endmodule : gpa_sync

// ### rtl/gpa_port.sv
// Purpose: general I/O port A registers behind an AXI4-Lite slave
// Assumes: configuration inputs are on the system clock
// Notes: unavailable bits read zero and leave their pad undriven
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
// What this block does
// - unimplemented bits of all four registers always read zero
// - on the small package, bits 10 to 7 are absent and read zero
// - bit 3 works only when the primary oscillator is disabled
// - bit 2 works only with oscillator disabled or external clock and clock pin off
// - reset loads direction 079F and the other three registers zero
module gpa_port
  import gpa_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic package_small, // smaller package variant
  input wire logic [1:0] primary_osc_mode, // oscillator mode setting
  input wire logic clock_pin_function_select, // clock output pin on
  input wire logic [15:0] pad_in, // pad levels
  output logic [15:0] pad_out, // pad output level
  output logic [15:0] pad_oe // pad drive enable
);
  logic [15:0] dir_r, dir_nxt;
  logic [15:0] lat_r, lat_nxt;
  logic [15:0] od_r, od_nxt;
  logic [15:0] out_r, out_nxt;
  logic [15:0] oe_r, oe_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic wrote_r, wrote_nxt;
  logic [15:0] avail;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] rd16;
  logic wr_en;
  logic rd_en;
  gpa_pin_if pins ();

  assign pins.raw = pad_in;

  gpa_sync #(.W(16)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .pins(pins)
  );

  always_comb begin
    avail = IMPL_MASK;
    if (package_small) begin
      avail = avail & ~BIG_PKG_MASK;
    end
    if (primary_osc_mode != OSC_DISABLED) begin
      avail[BIT_OSC_ONLY] = 1'b0;
    end
    if (!((primary_osc_mode == OSC_DISABLED || primary_osc_mode == OSC_EXT_CLOCK)
          && !clock_pin_function_select)) begin
      avail[BIT_CLK_PIN] = 1'b0;
    end
  end

  always_comb begin
    dir_nxt = dir_r;
    lat_nxt = lat_r;
    od_nxt = od_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    wrote_nxt = wrote_r;
    wr_en = 1'b0;
    rd_en = s_axi_arvalid && arready_r;
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    wmask = {{8{wstrb_nxt[1]}}, {8{wstrb_nxt[0]}}};
    wval = wdata_nxt[15:0];
    // both halves of the write are in and the response slot is free
    if (aw_have_nxt && w_have_nxt && !bvalid_r) begin
      wr_en = 1'b1;
      wrote_nxt = 1'b1;
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (awaddr_nxt[ADDR_W-1:2])
        IDX_DIR: dir_nxt = ((dir_r & ~wmask) | (wval & wmask)) & IMPL_MASK;
        IDX_LVL, IDX_LAT: lat_nxt = ((lat_r & ~wmask) | (wval & wmask)) & IMPL_MASK;
        IDX_ODC: od_nxt = ((od_r & ~wmask) | (wval & wmask)) & IMPL_MASK;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    rd16 = 16'h0000;
    if (rd_en) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (s_axi_araddr[ADDR_W-1:2])
        IDX_DIR: rd16 = dir_r;
        IDX_LVL: rd16 = pins.synced;
        IDX_LAT: rd16 = lat_r;
        IDX_ODC: rd16 = od_r;
        default: rresp_nxt = RESP_SLVERR;
      endcase
      rdata_nxt = {16'h0000, rd16 & avail};
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
    oe_nxt = avail & ~dir_nxt & ~(od_nxt & lat_nxt);
    out_nxt = avail & lat_nxt & ~od_nxt;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dir_r <= DIR_RESET;
      lat_r <= LAT_RESET;
      od_r <= ODC_RESET;
      out_r <= 16'h0000;
      oe_r <= 16'h0000;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
      wrote_r <= 1'b0;
    end else begin
      dir_r <= dir_nxt;
      lat_r <= lat_nxt;
      od_r <= od_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      wrote_r <= wrote_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pad_out = out_r;
  assign pad_oe = oe_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_unimpl_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & ~{16'h0000, IMPL_MASK}) == 0)
    else $error("unimplemented bit read nonzero");
  a_small_pkg: assert property (rd_en && package_small |=> s_axi_rdata[10:7] == 4'h0)
    else $error("small package high bits read nonzero");
  a_osc_bit3: assert property (rd_en && primary_osc_mode != OSC_DISABLED |=> !s_axi_rdata[3])
    else $error("bit 3 readable with oscillator on");
  a_clk_bit2: assert property (rd_en && (clock_pin_function_select
      || primary_osc_mode == 2'h1 || primary_osc_mode == 2'h2) |=> !s_axi_rdata[2])
    else $error("bit 2 readable while unavailable");
  a_reset_dir: assert property (!wrote_r |-> dir_r == DIR_RESET && lat_r == 16'h0000
      && od_r == 16'h0000)
    else $error("register moved from reset value without a write");
  a_input_nodrive: assert property ((pad_oe & dir_r) == 16'h0000)
    else $error("pad driven while direction is input");
  a_open_drain: assert property ((pad_out & od_r) == 16'h0000 && (pad_oe & od_r & lat_r) == 0)
    else $error("open drain pad driven high");
  a_read_lat: assert property (rd_en |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_write_answer: assert property (wr_en |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing after both halves taken");
  c_write_ok: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  c_write_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read_pin: cover property (rd_en && s_axi_araddr[ADDR_W-1:2] == IDX_LVL ##1 s_axi_rvalid);
  c_drive_low: cover property (|(pad_oe & ~pad_out & od_r));
endmodule : gpa_port

// ### testbench/tb_general_io_port_a_regs.sv
// Purpose: self-checking bench for the port A register block
// Assumes: AXI4-Lite master driven by non-blocking assignment at rising edges
// Notes: configuration, data and pads are random from a fixed seed
`timescale 1ns/1ns
module tb_general_io_port_a_regs;
  import gpa_pkg::*;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rdt;
  logic [3:0] sb = 4'hF;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic sm = 1'h0, ck = 1'h0;
  logic [1:0] osc = 2'h0, br, rr;
  logic [15:0] pin = 16'h0, po, poe, m, eoe;
  logic awr, wrd, bv, arr, rv;
  logic [15:0] v [4];
  logic [31:0] d, cfg;
  logic [1:0] r;
  logic [15:0] ed;
  logic [3:0] s4;
  int failures = 0, samples_checked = 0, seed = 17111;

  gpa_port u_gpa_port (.clock(clock), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(sb), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .package_small(sm),
    .primary_osc_mode(osc), .clock_pin_function_select(ck), .pad_in(pin), .pad_out(po),
    .pad_oe(poe));

  always #2 clock = ~clock;

  function automatic logic [11:0] adr(input int k);
    adr = {IDX_DIR + 10'(2 * k), 2'h0};
  endfunction : adr

  // pins that may work under a given package and clock configuration
  function automatic logic [15:0] avail(input logic s, input logic [1:0] o, input logic c);
    avail = 16'h079F;
    if (s) avail = avail & 16'hF87F;
    if (o != 2'h0) avail[3] = 1'h0;
    if (!((o == 2'h0 || o == 2'h3) && !c)) avail[2] = 1'h0;
  endfunction : avail

  // register value after a write with byte strobes, lanes 0 and 1 only
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
      input logic [3:0] s);
    merge = o;
    if (s[0]) merge[7:0] = n[7:0];
    if (s[1]) merge[15:8] = n[15:8];
  endfunction : merge

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] x, output logic [1:0] q);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge clock);
    awa <= a;
    wd <= x;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge clock);
      if (!ad && awr === 1'h1) begin
        ad = 1'h1;
        awv <= 1'h0;
      end
      if (!dd && wrd === 1'h1) begin
        dd = 1'h1;
        wv <= 1'h0;
      end
    end
    do @(posedge clock); while (bv !== 1'h1);
    q = br;
    bry <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] x, output logic [1:0] q);
    @(posedge clock);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do @(posedge clock); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge clock); while (rv !== 1'h1);
    x = rdt;
    q = rr;
    rry <= 1'h0;
  endtask : rd_reg

  task automatic wrap_up;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'h1;
    chk("oe_rst", {16'h0, poe}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rd_reg(adr(k), d, r);
      chk("rst_val", d, (k == 0) ? 32'h079F : 32'h0);
    end
    for (int i = 0; i < 40; i++) begin
      cfg = $random(seed);
      if (i < 16) cfg[3:0] = i[3:0];
      sm <= cfg[0];
      osc <= cfg[2:1];
      ck <= cfg[3];
      pin <= cfg[31:16];
      m = avail(cfg[0], cfg[2:1], cfg[3]);
      for (int k = 0; k < 4; k++) v[k] = 16'($random(seed));
      for (int k = 0; k < 4; k++) begin
        if (k != 1) begin
          // the latch is reached through its own or the pin level address
          wr_reg((k == 2 && cfg[4]) ? adr(1) : adr(k), {16'($random(seed)), v[k]}, r);
          chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
        end
      end
      for (int k = 0; k < 4; k++) begin
        rd_reg(adr(k), d, r);
        chk("rdata", d, {16'h0, ((k == 1) ? cfg[31:16] : v[k]) & m});
      end
      eoe = ~v[0] & ~(v[3] & v[2]) & m;
      chk("pad_oe", {16'h0, poe}, {16'h0, eoe});
      chk("pad_out", {16'h0, po & poe}, {16'h0, v[2] & eoe});
    end
    wr_reg(12'hB04, 32'h0000FFFF, r);
    chk("bad_wr", {30'h0, r}, {30'h0, RESP_SLVERR});
    rd_reg(12'hB04, d, r);
    chk("bad_rd", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
    // an unmapped write leaves the direction register alone
    ed = v[0];
    rd_reg(adr(0), d, r);
    chk("bad_keep", d, {16'h0, ed & m});
    for (int i = 0; i < 8; i++) begin
      s4 = 4'($random(seed));
      if (i == 0) s4 = 4'h1;
      if (i == 1) s4 = 4'h2;
      v[0] = 16'($random(seed));
      sb <= s4;
      wr_reg(adr(0), {16'($random(seed)), v[0]}, r);
      ed = merge(ed, v[0], s4);
      rd_reg(adr(0), d, r);
      chk("strobe", d, {16'h0, ed & m});
    end
    sb <= 4'hF;
    // second reset in mid-run, every reset reloads the registers
    @(posedge clock);
    nrst <= 1'h0;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        rd_reg(adr(k), d, r);
        chk("rst_val2", d, {16'h0, ((k == 0) ? 16'h079F : 16'h0000) & m});
      end
    end
    chk("oe_rst2", {16'h0, poe}, 32'h0);
    wrap_up();
  end
endmodule : tb_general_io_port_a_regs
